// File: core/move_shift_alu.sv
// Package of shared constants and the combinational shift and unary operation unit
`timescale 1ns/10ps

package cpu_ops_pkg;

  // Datapath and port widths
  localparam int DATA_W     = 8;                 // Width of one data byte
  localparam int REG_IDX_W  = 4;                 // Width of a register file index
  localparam int MEM_ADDR_W = 16;                // Width of a data memory address

  // Field positions inside a data byte
  localparam int MSB_POS    = 7;                 // Sign bit, shifted out on left shifts
  localparam int LSB_POS    = 0;                 // Bit shifted out on right shifts

  // Reset values of the core state held here, and byte constants
  localparam logic [7:0] ACC_RESET      = 8'h00; // Accumulator after reset
  localparam logic       CARRY_RESET    = 1'b0;  // Carry flag after reset
  localparam logic       OVERFLOW_RESET = 1'b0;  // Overflow flag after reset
  localparam logic       ZERO_RESET     = 1'b1;  // Zero flag matches the cleared accumulator
  localparam logic       SKIP_RESET     = 1'b0;  // No conditional move skipped yet
  localparam logic [7:0] BYTE_ZERO      = 8'h00; // All-zero byte
  localparam logic [7:0] BYTE_ONE       = 8'h01; // Constant one for increment forms

  // Operations handled by this unit
  typedef enum logic [3:0] {
    OP_NONE,                                     // No operation this cycle
    OP_MOVE_CARRY_CLEAR,                         // Conditional move when carry is 0
    OP_MOVE_CARRY_SET,                           // Conditional move when carry is 1
    OP_SHIFT_LEFT,                               // Logical left shift
    OP_SHIFT_LEFT_CARRY,                         // Left shift through carry
    OP_SHIFT_RIGHT,                              // Logical right shift
    OP_SHIFT_RIGHT_CARRY,                        // Right shift through carry
    OP_SHIFT_RIGHT_ARITH,                        // Arithmetic right shift
    OP_ONES_COMPLEMENT,                          // ones_complement_op
    OP_TWOS_COMPLEMENT,                          // twos_complement_op
    OP_TWOS_COMPLEMENT_CHAINED,                  // twos_complement_chained_op
    OP_INCREMENT,                                // Add one
    OP_INCREMENT_CHAINED,                        // Add incoming carry
    OP_STORE_REG,                                // Store a register byte into memory
    OP_STORE_IMM                                 // Store an immediate byte into memory
  } opcode_t;

  // Byte plus a single bit, wrapping at eight bits
  function automatic logic [7:0] addBit(input logic [7:0] b, input logic cin);
    addBit = 8'(b + {7'h00, cin});
  endfunction : addBit

  // Signed overflow of adding a non-negative bit to a byte
  function automatic logic incOverflow(input logic [7:0] a, input logic [7:0] r);
    incOverflow = ~a[MSB_POS] & r[MSB_POS];
  endfunction : incOverflow

  // True for operations that read an operand and load the accumulator
  function automatic logic isComputeOp(input opcode_t op);
    isComputeOp = (op != OP_NONE) && (op != OP_STORE_REG) && (op != OP_STORE_IMM);
  endfunction : isComputeOp

  // True for operations that only store into data memory
  function automatic logic isStoreOp(input opcode_t op);
    isStoreOp = (op == OP_STORE_REG) || (op == OP_STORE_IMM);
  endfunction : isStoreOp

endpackage : cpu_ops_pkg

// Purely combinational: the result is ready in the same cycle as the operand
module move_shift_alu
  import cpu_ops_pkg::*;
(
  // Operation and operands
  input  opcode_t    opCode,                     // Operation to perform
  input  logic [7:0] src,                        // Source byte, register or memory
  input  logic       carryIn,                    // Present carry flag
  input  logic       overflowIn,                 // Present overflow flag
  // Results
  output logic [7:0] result,                     // Byte for accumulator and destination
  output logic       carryOut,                   // Next carry flag
  output logic       overflowOut,                // Next overflow flag
  output logic       writeDest                   // Destination register is to be written
);

  // One case over the operation; flags not named by an operation hold their value
  always_comb begin
    result      = src;
    carryOut    = carryIn;
    overflowOut = overflowIn;
    writeDest   = 1'b1;
    case (opCode)
      OP_MOVE_CARRY_CLEAR: begin
        writeDest = ~carryIn;
      end
      OP_MOVE_CARRY_SET: begin
        writeDest = carryIn;
      end
      OP_SHIFT_LEFT: begin
        result      = {src[6:0], 1'b0};
        carryOut    = src[MSB_POS];
        overflowOut = src[MSB_POS] ^ src[6];
      end
      OP_SHIFT_LEFT_CARRY: begin
        result      = {src[6:0], carryIn};
        carryOut    = src[MSB_POS];
        overflowOut = src[MSB_POS] ^ src[6];
      end
      OP_SHIFT_RIGHT: begin
        result      = {1'b0, src[7:1]};
        carryOut    = src[LSB_POS];
        overflowOut = src[MSB_POS];
      end
      OP_SHIFT_RIGHT_CARRY: begin
        result      = {carryIn, src[7:1]};
        carryOut    = src[LSB_POS];
        overflowOut = src[MSB_POS] ^ carryIn;
      end
      OP_SHIFT_RIGHT_ARITH: begin
        // Sign is kept, so the signed value can never overflow
        result      = {src[MSB_POS], src[7:1]};
        carryOut    = src[LSB_POS];
        overflowOut = 1'b0;
      end
      OP_ONES_COMPLEMENT: begin
        result = ~src;
      end
      OP_TWOS_COMPLEMENT: begin
        result      = addBit(~src, 1'b1);
        carryOut    = (result == BYTE_ZERO);
        overflowOut = incOverflow(~src, result);
      end
      OP_TWOS_COMPLEMENT_CHAINED: begin
        result      = addBit(~src, carryIn);
        carryOut    = (result == BYTE_ZERO) & carryIn;
        overflowOut = incOverflow(~src, result);
      end
      OP_INCREMENT: begin
        result      = 8'(src + BYTE_ONE);
        carryOut    = (result == BYTE_ZERO);
        overflowOut = incOverflow(src, result);
      end
      OP_INCREMENT_CHAINED: begin
        result      = addBit(src, carryIn);
        carryOut    = (result == BYTE_ZERO) & carryIn;
        overflowOut = incOverflow(src, result);
      end
      default: begin
        // No operation and stores write no register
        writeDest = 1'b0;
      end
    endcase
  end

endmodule : move_shift_alu

// File: core/move_shift_unit.sv
// Conditional move, shift, complement and increment datapath with accumulator and flags
`timescale 1ns/10ps

// Operation
// - Carry-clear move: load accumulator, write when C=0
// - Memory carry-clear move: accumulator always, register when C=0
// - Carry-set move: load accumulator, write when C=1
// - Left shift: zero in, old bit 7 to carry
// - Left shift through carry: carry into bit 0
// - Right shift: zero in bit 7, bit 0 out
// - Right shift through carry: carry into bit 7
// - Arithmetic right shift keeps sign, bit 0 out
// - Memory shift forms never write memory
// - Ones complement inverts, touches only zero flag
// - Memory ones complement never writes memory
// - Twos complement: carry set when result zero
// - Chained twos complement: carry when zero and carry
// - Increment: carry set when result wraps zero
// - Chained increment: carry when zero and carry
// - Memory increment: same carry rule, no memory write
// - Zero flag follows the updated accumulator
// - Overflow flag reports signed overflow
module move_shift_unit
  import cpu_ops_pkg::*;
#(
  parameter int REG_W  = REG_IDX_W,              // Register index width
  parameter int ADDR_W = MEM_ADDR_W              // Data memory address width
) (
  // Clock and reset
  input  logic              clock,               // Core clock, 20 MHz
  input  logic              reset,               // Synchronous, active high
  // Instruction issue from the decoder
  input  logic              opValid,             // An operation is issued this cycle
  input  opcode_t           opCode,              // Which operation
  input  logic              srcFromMem,          // Operand comes from data memory
  input  logic [REG_W-1:0]  destIdx,             // Destination register index
  input  logic [7:0]        srcRegData,          // Source register byte from register file
  input  logic [ADDR_W-1:0] eaddr,               // Resolved extended address
  input  logic [7:0]        immData,             // Immediate byte for stores
  // Data memory port
  output logic              memRdEn,             // Read strobe, data valid same cycle
  output logic [ADDR_W-1:0] memRdAddr,           // Read address
  input  logic [7:0]        memRdData,           // Read data from data memory
  output logic              memWrEn,             // Write strobe, taken at the clock edge
  output logic [ADDR_W-1:0] memWrAddr,           // Write address
  output logic [7:0]        memWrData,           // Write data
  // Register file write port
  output logic              regWrEn,             // Write strobe, taken at the clock edge
  output logic [REG_W-1:0]  regWrIdx,            // Register written
  output logic [7:0]        regWrData,           // Byte written
  // Updates from the rest of the core
  input  logic              extLoad,             // Another unit loads accumulator and flags
  input  logic [7:0]        extAcc,              // Its accumulator value
  input  logic              extCarry,            // Its carry value
  input  logic              extOverflow,         // Its overflow value
  // Core state
  output logic [7:0]        accumulator,         // Accumulator a
  output logic              carryFlag,           // Carry flag C
  output logic              overflowFlag,        // Overflow flag V
  output logic              zeroFlag,            // Zero flag Z
  output logic              moveSkipped          // Last conditional move left its target
);

  // Accumulator and flag registers
  logic [7:0] acc_r;                             // Accumulator
  logic [7:0] acc_nxt;                           // Next accumulator
  logic       carry_r;                           // Carry flag
  logic       carry_nxt;                         // Next carry flag
  logic       overflow_r;                        // Overflow flag
  logic       overflow_nxt;                      // Next overflow flag
  logic       zero_r;                            // Zero flag
  logic       zero_nxt;                          // Next zero flag

  // Status register for conditional moves
  logic       skip_r;                            // Last conditional move was suppressed
  logic       skip_nxt;                          // Next value of the above

  // Datapath wires
  logic [7:0] operand;                           // Selected source byte
  logic [7:0] aluResult;                         // Byte from the operation unit
  logic       aluCarry;                          // Carry from the operation unit
  logic       aluOverflow;                       // Overflow from the operation unit
  logic       aluWriteDest;                      // Operation unit asks for a register write
  logic       computeIssued;                     // A computing operation is issued
  logic       storeIssued;                       // A store operation is issued
  logic       condMove;                          // Issued operation is a conditional move

  // Issue qualifiers, decoded once and shared below
  always_comb begin
    computeIssued = opValid && isComputeOp(opCode);
    storeIssued   = opValid && isStoreOp(opCode);
    condMove      = opValid &&
                    ((opCode == OP_MOVE_CARRY_CLEAR) || (opCode == OP_MOVE_CARRY_SET));
  end

  // Memory read and operand selection; memory data is combinational within the cycle
  always_comb begin
    memRdEn   = computeIssued && srcFromMem;
    memRdAddr = eaddr;
    if (srcFromMem) begin
      operand = memRdData;
    end else begin
      operand = srcRegData;
    end
  end

  // Shift and unary arithmetic, entirely combinational so that one cycle suffices
  move_shift_alu u_alu (
    .opCode      (opCode),
    .src         (operand),
    .carryIn     (carry_r),
    .overflowIn  (overflow_r),
    .result      (aluResult),
    .carryOut    (aluCarry),
    .overflowOut (aluOverflow),
    .writeDest   (aluWriteDest)
  );

  // Register file write; the file takes it at the same edge as the accumulator,
  // so the next instruction already reads the new register value
  always_comb begin
    regWrEn   = computeIssued && aluWriteDest;
    regWrIdx  = destIdx;
    regWrData = aluResult;
  end

  // Memory write only for stores; memory-operand computations never write back,
  // which also keeps a read and a write of one location out of the same cycle
  always_comb begin
    memWrEn   = storeIssued;
    memWrAddr = eaddr;
    if (opCode == OP_STORE_IMM) begin
      memWrData = immData;
    end else begin
      memWrData = srcRegData;
    end
  end

  // Next accumulator and flags
  always_comb begin
    acc_nxt      = acc_r;
    carry_nxt    = carry_r;
    overflow_nxt = overflow_r;
    zero_nxt     = zero_r;
    if (computeIssued) begin
      // Accumulator always loads, even when a conditional move skips its target
      acc_nxt      = aluResult;
      // The unit passes carry and overflow through for moves and ones complement
      carry_nxt    = aluCarry;
      overflow_nxt = aluOverflow;
      zero_nxt     = (aluResult == BYTE_ZERO);
    end else if (storeIssued) begin
      // Stores touch neither accumulator nor any flag
      acc_nxt = acc_r;
    end else if (extLoad) begin
      // Other execution units share the same accumulator and flags;
      // an operation of this unit wins because it is tested before extLoad
      acc_nxt      = extAcc;
      carry_nxt    = extCarry;
      overflow_nxt = extOverflow;
      zero_nxt     = (extAcc == BYTE_ZERO);
    end
  end

  // Accumulator and flag registers
  always_ff @(posedge clock) begin
    if (reset) begin
      acc_r      <= ACC_RESET;
      carry_r    <= CARRY_RESET;
      overflow_r <= OVERFLOW_RESET;
      zero_r     <= ZERO_RESET;
    end else begin
      acc_r      <= acc_nxt;
      carry_r    <= carry_nxt;
      overflow_r <= overflow_nxt;
      zero_r     <= zero_nxt;
    end
  end

  // Conditional move status: records whether the last move skipped its target
  always_comb begin
    skip_nxt = skip_r;
    if (condMove) begin
      skip_nxt = ~aluWriteDest;
    end
  end

  // Status register
  always_ff @(posedge clock) begin
    if (reset) begin
      skip_r <= SKIP_RESET;
    end else begin
      skip_r <= skip_nxt;
    end
  end

  // State outputs straight from the registers
  always_comb begin
    accumulator  = acc_r;
    carryFlag    = carry_r;
    overflowFlag = overflow_r;
    zeroFlag     = zero_r;
    moveSkipped  = skip_r;
  end

endmodule : move_shift_unit

// File: testbench/move_shift_unit_chk.sv
// Port checker for the move, shift and unary datapath, bound to its top module
`timescale 1ns/10ps

module move_shift_unit_chk
  import cpu_ops_pkg::*;
(
  // Clock and reset
  input logic       clock,
  input logic       reset,
  // Issue side
  input logic       opValid,
  input opcode_t    opCode,
  input logic       srcFromMem,
  input logic [7:0] srcRegData,
  input logic [7:0] memRdData,
  // Write strobes and result
  input logic       memWrEn,
  input logic       regWrEn,
  input logic [7:0] regWrData,
  // Core state
  input logic [7:0] accumulator,
  input logic       carryFlag,
  input logic       overflowFlag,
  input logic       zeroFlag
);
  // Operand as selected by the issue port, and the compute qualifier
  logic [7:0] opnd;
  logic       compute;
  assign opnd    = srcFromMem ? memRdData : srcRegData;
  assign compute = opValid && !(opCode inside {OP_NONE, OP_STORE_REG, OP_STORE_IMM});

  // Everything here lives in the core clock domain
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);

  a_move_clear_gate: assert property (
    opValid && opCode == OP_MOVE_CARRY_CLEAR |-> regWrEn == !carryFlag)
    else $error("carry-clear move write gate wrong");
  a_move_set_gate: assert property (
    opValid && opCode == OP_MOVE_CARRY_SET |-> regWrEn == carryFlag)
    else $error("carry-set move write gate wrong");
  a_shl_carry_out: assert property (
    opValid && opCode == OP_SHIFT_LEFT |=> carryFlag == $past(opnd[7]))
    else $error("left shift carry is not the old top bit");
  a_shr_carry_out: assert property (
    opValid && opCode inside {OP_SHIFT_RIGHT, OP_SHIFT_RIGHT_CARRY, OP_SHIFT_RIGHT_ARITH}
    |=> carryFlag == $past(opnd[0]))
    else $error("right shift carry is not the old low bit");
  a_compute_no_memwr: assert property (compute |-> !memWrEn)
    else $error("compute operation wrote memory");
  a_ones_keeps_cv: assert property (
    opValid && opCode == OP_ONES_COMPLEMENT |=> $stable(carryFlag) && $stable(overflowFlag))
    else $error("ones complement touched carry or overflow");
  a_twos_result: assert property (
    opValid && opCode == OP_TWOS_COMPLEMENT |-> regWrData == 8'(~opnd + 8'h01))
    else $error("twos complement result wrong");
  a_inc_wrap_carry: assert property (
    opValid && opCode == OP_INCREMENT |=> carryFlag == (accumulator == 8'h00))
    else $error("increment carry does not follow wrap");
  a_zero_tracks_acc: assert property (zeroFlag == (accumulator == 8'h00))
    else $error("zero flag disagrees with accumulator");
  a_store_keeps_state: assert property (
    opValid && opCode inside {OP_STORE_REG, OP_STORE_IMM}
    |-> memWrEn && !regWrEn ##1 $stable(accumulator) && $stable({carryFlag, overflowFlag}))
    else $error("store disturbed accumulator or flags");
  a_acc_one_cycle: assert property (compute |=> accumulator == $past(regWrData))
    else $error("accumulator not loaded in one cycle");

  // Main scenarios reached
  c_move_skipped: cover property (opValid && opCode == OP_MOVE_CARRY_SET && !regWrEn);
  c_inc_wrap: cover property (opValid && opCode == OP_INCREMENT ##1 carryFlag);
  c_store: cover property (opValid && memWrEn);
endmodule : move_shift_unit_chk

bind move_shift_unit move_shift_unit_chk chk (
  .clock(clock), .reset(reset), .opValid(opValid), .opCode(opCode), .srcFromMem(srcFromMem),
  .srcRegData(srcRegData), .memRdData(memRdData), .memWrEn(memWrEn), .regWrEn(regWrEn),
  .regWrData(regWrData), .accumulator(accumulator), .carryFlag(carryFlag),
  .overflowFlag(overflowFlag), .zeroFlag(zeroFlag)
);

// File: testbench/cpu_move_shift_unary_ops_tb_top.sv
// Self-checking bench for the move, shift and unary datapath
`timescale 1ns/10ps

module cpu_move_shift_unary_ops_tb_top import cpu_ops_pkg::*;;
  // Stimulus and observed signals
  logic        clock, reset, opValid, srcFromMem, extLoad, extCarry, extOverflow;
  opcode_t     opCode;
  logic [3:0]  destIdx, regWrIdx;
  logic [7:0]  srcRegData, immData, memRdData, extAcc, memWrData, regWrData, accumulator;
  logic [15:0] eaddr, memRdAddr, memWrAddr;
  logic        memRdEn, memWrEn, regWrEn, carryFlag, overflowFlag, zeroFlag, moveSkipped;
  int          error_cnt = 0;
  int          checked = 0;

  move_shift_unit uut (
    .clock(clock), .reset(reset), .opValid(opValid), .opCode(opCode), .srcFromMem(srcFromMem),
    .destIdx(destIdx), .srcRegData(srcRegData), .eaddr(eaddr), .immData(immData),
    .memRdEn(memRdEn), .memRdAddr(memRdAddr), .memRdData(memRdData), .memWrEn(memWrEn),
    .memWrAddr(memWrAddr), .memWrData(memWrData), .regWrEn(regWrEn), .regWrIdx(regWrIdx),
    .regWrData(regWrData), .extLoad(extLoad), .extAcc(extAcc), .extCarry(extCarry),
    .extOverflow(extOverflow), .accumulator(accumulator), .carryFlag(carryFlag),
    .overflowFlag(overflowFlag), .zeroFlag(zeroFlag), .moveSkipped(moveSkipped)
  );

  // 20 MHz core clock
  always #25 clock = ~clock;

  // Compare one value, count it, report a mismatch
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // Reference behaviour: result, next carry, next overflow, register write
  function automatic void model(input opcode_t op, input logic [7:0] s, input logic c,
      output logic [7:0] r, output logic co, output logic vo, output logic wr);
    r  = s;
    co = c;
    vo = ~c;
    wr = 1'b1;
    case (op)
      OP_MOVE_CARRY_CLEAR:        wr = ~c;
      OP_MOVE_CARRY_SET:          wr = c;
      OP_SHIFT_LEFT:              {r, co, vo} = {s[6:0], 1'b0, s[7], s[7] ^ s[6]};
      OP_SHIFT_LEFT_CARRY:        {r, co, vo} = {s[6:0], c, s[7], s[7] ^ s[6]};
      OP_SHIFT_RIGHT:             {r, co, vo} = {1'b0, s[7:1], s[0], s[7]};
      OP_SHIFT_RIGHT_CARRY:       {r, co, vo} = {c, s[7:1], s[0], s[7] ^ c};
      OP_SHIFT_RIGHT_ARITH:       {r, co, vo} = {s[7], s[7:1], s[0], 1'b0};
      OP_ONES_COMPLEMENT:         r = ~s;
      OP_TWOS_COMPLEMENT:         r = ~s + 8'h01;
      OP_TWOS_COMPLEMENT_CHAINED: r = ~s + {7'h00, c};
      OP_INCREMENT:               r = s + 8'h01;
      OP_INCREMENT_CHAINED:       r = s + {7'h00, c};
      default:                    wr = 1'b1;
    endcase
    // Arithmetic forms: carry only on a zero result, chained forms also need carry in
    if (op >= OP_TWOS_COMPLEMENT) begin
      co = (r == 8'h00) && (op == OP_TWOS_COMPLEMENT || op == OP_INCREMENT || c);
      vo = (op <= OP_TWOS_COMPLEMENT_CHAINED ? s[7] : ~s[7]) & r[7];
    end
  endfunction : model

  // Preload flags through the external load, issue one op, judge strobes then state
  task automatic runOp(input opcode_t op, input logic mem, input logic [7:0] s, input logic c);
    logic [7:0] r;
    logic       co, vo, wr;
    model(op, s, c, r, co, vo, wr);
    @(posedge clock);
    extLoad <= 1'b1;
    extAcc <= 8'hA5;
    extCarry <= c;
    extOverflow <= ~c;
    @(posedge clock);
    extLoad <= 1'b0;
    opValid <= 1'b1;
    opCode <= op;
    srcFromMem <= mem;
    destIdx <= s[3:0];
    eaddr <= {~s, s};
    // The unused source carries the inverse so a wrong select shows
    srcRegData <= mem ? ~s : s;
    memRdData <= mem ? s : ~s;
    #1;
    check("memRdEn", memRdEn, mem);
    check("memRdAddr", memRdAddr[15:8], ~s);
    check("regWrIdx", {4'h0, regWrIdx}, {4'h0, s[3:0]});
    check("memWrEn", memWrEn, 8'h00);
    check("regWrEn", regWrEn, wr);
    check("regWrData", regWrData, r);
    @(posedge clock);
    opValid <= 1'b0;
    #1;
    check("accumulator", accumulator, r);
    check("flags CVZ", {carryFlag, overflowFlag, zeroFlag}, {co, vo, r == 8'h00});
    // Skip status only changes on conditional moves
    if (op == OP_MOVE_CARRY_CLEAR || op == OP_MOVE_CARRY_SET) begin
      check("moveSkipped", moveSkipped, !wr);
    end
  endtask : runOp

  // Both conditional moves, both sources, both carry states
  task automatic test_moves();
    for (int k = 0; k < 8; k++) begin
      runOp(k[2] ? OP_MOVE_CARRY_SET : OP_MOVE_CARRY_CLEAR, k[0], k[0] ? 8'h00 : 8'h9C,
            k[1]);
    end
  endtask : test_moves

  // Every shift with boundary bytes, register and memory operands
  task automatic test_shifts();
    logic [7:0] vals [4] = '{8'h81, 8'h40, 8'hC0, 8'h01};
    for (int o = OP_SHIFT_LEFT; o <= OP_SHIFT_RIGHT_ARITH; o++) begin
      for (int k = 0; k < 4; k++) begin
        runOp(opcode_t'(o), k[0], vals[k], k[1]);
      end
    end
  endtask : test_shifts

  // Complement and increment forms, including wrap to zero with carry in
  task automatic test_unary();
    logic [7:0] vals [6] = '{8'h00, 8'hFF, 8'h7F, 8'hFF, 8'h00, 8'h80};
    for (int o = OP_ONES_COMPLEMENT; o <= OP_INCREMENT_CHAINED; o++) begin
      for (int k = 0; k < 6; k++) begin
        runOp(opcode_t'(o), k[0], vals[k], k >= 3);
      end
    end
  endtask : test_unary

  // Back-to-back stores must write memory and leave accumulator and flags alone
  task automatic test_stores();
    runOp(OP_INCREMENT, 1'b0, 8'h3B, 1'b1);
    @(posedge clock);
    opValid <= 1'b1;
    opCode <= OP_STORE_IMM;
    immData <= 8'h5A;
    eaddr <= 16'h02F0;
    #1;
    check("memWrEn imm", memWrEn, 8'h01);
    check("memWrData imm", memWrData, 8'h5A);
    check("memWrAddr", memWrAddr[7:0], 8'hF0);
    @(posedge clock);
    opCode <= OP_STORE_REG;
    srcRegData <= 8'hC3;
    #1;
    check("regWrEn store", regWrEn, 8'h00);
    check("memWrData reg", memWrData, 8'hC3);
    @(posedge clock);
    opValid <= 1'b0;
    #1;
    check("accumulator store", accumulator, 8'h3C);
    check("flags store", {carryFlag, overflowFlag, zeroFlag}, 8'h00);
  endtask : test_stores

  // Later ops see the new carry, back to back too; an external load in the same cycle loses
  task automatic test_chain();
    runOp(OP_INCREMENT_CHAINED, 1'b0, 8'hFF, 1'b1);
    @(posedge clock);
    opValid <= 1'b1;
    opCode <= OP_SHIFT_RIGHT_CARRY;
    srcFromMem <= 1'b0;
    srcRegData <= 8'h00;
    extLoad <= 1'b1;
    extAcc <= 8'h77;
    @(posedge clock);
    // Issued straight after the shift: a stale carry of 1 would wrap to zero
    opCode <= OP_INCREMENT_CHAINED;
    srcRegData <= 8'hFF;
    extLoad <= 1'b0;
    #1;
    check("accumulator chain", accumulator, 8'h80);
    check("carry chain", carryFlag, 8'h00);
    @(posedge clock);
    opValid <= 1'b0;
    #1;
    check("accumulator next", accumulator, 8'hFF);
    check("carry next", carryFlag, 8'h00);
  endtask : test_chain

  // Verdict and end of run
  task automatic complete_run();
    $display("Comparisons %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : complete_run

  // Watchdog: the sequence needs well under 1000 cycles
  initial begin
    #(50 * 20000);
    error_cnt++;
    complete_run();
  end

  // Main sequence
  initial begin
    {clock, opValid, srcFromMem, extLoad, extCarry, extOverflow} = '0;
    reset = 1'b1;
    opCode = OP_NONE;
    {destIdx, srcRegData, immData, memRdData, extAcc, eaddr} = '0;
    repeat (6) @(posedge clock);
    reset <= 1'b0;
    #1;
    check("reset accumulator", accumulator, 8'h00);
    check("reset SCVZ", {moveSkipped, carryFlag, overflowFlag, zeroFlag}, 8'h01);
    test_moves();
    test_shifts();
    test_unary();
    test_stores();
    test_chain();
    complete_run();
  end
endmodule : cpu_move_shift_unary_ops_tb_top
